// File: rtl/usbs_sie_regs.sv
// SIE status flags, device address and endpoint FIFO command port behind APB
//
// Functional notes
// R1: With auto address set, address loads only after a successful IN read.
// R2: With auto address clear, address is taken when firmware writes it.
// R3: Engine clears auto address flag after the deferred update.
// R4: FIFO0 access error sets a sticky flag; firmware clears; resets zero.
// R5: OUT token with data sets OUT flag, not zero-length OUT.
// R6: OUT flag is also cleared by the next valid SETUP token.
// R7: IN status bit shows the current token is an IN token.
// R8: NAK status bit is high while a NAK handshake is sent.
// R9: CRC error sets the checksum error flag; firmware clears it.
// R10: Transaction end flag reads one normally; zero with suspend is a fault.
// R11: Mask one interrupts on data only; zero interrupts on any FIFO0 access.
// R12: FIFO command register is zeroed on USB bus reset.
// R13: Firmware sets fields first, then request, clears request when done.
// R14: For writes firmware sets direction, clears it before dropping request.
// R15: For reads direction stays zero, set to one before releasing request.
// R16: Clear bit empties the requested FIFO even when not ready.
// R17: Select field 00, 01, 10 picks FIFO0, FIFO1, FIFO2; 11 reserved.
// R18: SETUP marker sets when FIFO holds a SETUP command; firmware clears.
// R19: Ready bit reports the selected FIFO is ready.
// R20: Zero-length bit sets when host sends a zero-length packet.
// R21: Firmware spaces FIFO data reads or writes by at least 2 us.
// R22: A hardware set wins over a firmware clear in the same cycle.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "usbs_cfg.svh"

module usbs_sie_regs #(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sie_in_token,
  input wire logic sie_nak_tx,
  input wire logic sie_eot,
  input wire logic sie_suspend,
  input wire logic sie_crc_err,
  input wire logic sie_fifo0_err,
  input wire logic sie_out_data,
  input wire logic sie_setup_token,
  input wire logic sie_in_done,
  input wire logic sie_setup_in_fifo,
  input wire logic sie_zero_len_pkt,
  input wire logic sie_fifo0_access,
  input wire logic sie_data_xfer,
  input wire logic usb_bus_reset,
  input wire logic [2:0] fifo_ready,
  output logic [6:0] dev_addr,
  output logic remote_wake_en,
  output logic fifo_req,
  output logic fifo_dir_write,
  output logic fifo_flush,
  output logic [1:0] fifo_select,
  output logic usb_irq,
  output logic usb_fault
);

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] AWR_ADDR = ADDR_W'({`USBS_IDX_AWR, 2'b00});
  localparam logic [ADDR_W-1:0] SIE_STATUS_FLAGS_ADDR = ADDR_W'({`USBS_IDX_SIE_STATUS_FLAGS, 2'b00});
  localparam logic [ADDR_W-1:0] MISC_ADDR = ADDR_W'({`USBS_IDX_MISC, 2'b00});

  logic hit_awr;
  logic hit_sie_status_flags;
  logic hit_misc;
  logic mapped;
  logic wr_en;
  logic [7:0] wd;

  assign hit_awr = (paddr == AWR_ADDR);
  assign hit_sie_status_flags = (paddr == SIE_STATUS_FLAGS_ADDR);
  assign hit_misc = (paddr == MISC_ADDR);
  assign mapped = hit_awr | hit_sie_status_flags | hit_misc;
  assign wr_en = psel & penable & pwrite & mapped;
  assign wd = pwdata[7:0];
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // ----------------------------------------
  // State
  // ----------------------------------------
  usbs_pkg::usbs_byte_t awr_q;
  logic [6:0] dev_addr_q;
  logic adr_set_q;
  logic fifo0_access_error_q;
  logic out_q;
  logic crc_q;
  logic nmi_q;
  logic [4:0] cmd_q;
  logic setup_mk_q;
  logic zero_length_packet_flag_q;
  logic irq_q;
  logic [31:0] prdata_q;
  logic ready_sel;
  usbs_pkg::usbs_ep_e ep_sel;
  usbs_pkg::usbs_byte_t sie_status_flags_rd;
  usbs_pkg::usbs_byte_t misc_rd;

  assign ep_sel = usbs_pkg::usbs_ep_e'(cmd_q[`USBS_FC_SEL_HI:`USBS_FC_SEL_LO]);

  // R17 select decode
  always_comb begin
    case (ep_sel)
      usbs_pkg::USBS_EP_FIFO0: ready_sel = fifo_ready[0];
      usbs_pkg::USBS_EP_FIFO1: ready_sel = fifo_ready[1];
      usbs_pkg::USBS_EP_FIFO2: ready_sel = fifo_ready[2];
      default: ready_sel = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Address register and device address
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      awr_q <= `USBS_RST_AWR;
    end else if (wr_en && hit_awr) begin
      awr_q <= wd;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dev_addr_q <= 7'h00;
    // R2 immediate load
    end else if (wr_en && hit_awr && !adr_set_q) begin
      dev_addr_q <= wd[7:1];
    // R1 deferred load
    end else if (adr_set_q && sie_in_done) begin
      dev_addr_q <= awr_q[7:1];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adr_set_q <= 1'b0;
    // R3 self clear
    end else if (adr_set_q && sie_in_done) begin
      adr_set_q <= 1'b0;
    end else if (wr_en && hit_sie_status_flags) begin
      adr_set_q <= wd[`USBS_SF_ADR_SET];
    end
  end

  // ----------------------------------------
  // Sticky status flags and interrupt mask bit
  // ----------------------------------------
  logic sie_status_flags_wr;
  assign sie_status_flags_wr = wr_en & hit_sie_status_flags;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo0_access_error_q <= 1'b0;
    // R4 R22 error set wins
    end else if (sie_fifo0_err) begin
      fifo0_access_error_q <= 1'b1;
    end else if (sie_status_flags_wr) begin
      fifo0_access_error_q <= wd[`USBS_SF_FIFO0_ACCESS_ERROR];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= 1'b0;
    // R5 R22 data OUT sets
    end else if (sie_out_data) begin
      out_q <= 1'b1;
    // R6 SETUP clears
    end else if (sie_setup_token) begin
      out_q <= 1'b0;
    end else if (sie_status_flags_wr) begin
      out_q <= wd[`USBS_SF_OUT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_q <= 1'b0;
    // R9 R22 CRC set wins
    end else if (sie_crc_err) begin
      crc_q <= 1'b1;
    end else if (sie_status_flags_wr) begin
      crc_q <= wd[`USBS_SF_CRC];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_q <= 1'b0;
    end else if (sie_status_flags_wr) begin
      nmi_q <= wd[`USBS_SF_NMI];
    end
  end

  // R7 R8 R10 live status bits
  always_comb begin
    sie_status_flags_rd = `USBS_RST_BYTE;
    sie_status_flags_rd[`USBS_SF_ADR_SET] = adr_set_q;
    sie_status_flags_rd[`USBS_SF_FIFO0_ACCESS_ERROR] = fifo0_access_error_q;
    sie_status_flags_rd[`USBS_SF_OUT] = out_q;
    sie_status_flags_rd[`USBS_SF_IN] = sie_in_token;
    sie_status_flags_rd[`USBS_SF_NAK] = sie_nak_tx;
    sie_status_flags_rd[`USBS_SF_CRC] = crc_q;
    sie_status_flags_rd[`USBS_SF_EOT] = sie_eot;
    sie_status_flags_rd[`USBS_SF_NMI] = nmi_q;
  end

  // ----------------------------------------
  // FIFO command register
  // ----------------------------------------
  logic misc_wr;
  assign misc_wr = wr_en & hit_misc;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= 5'h00;
    // R12 bus reset zeroes
    end else if (usb_bus_reset) begin
      cmd_q <= 5'h00;
    end else if (misc_wr) begin
      cmd_q <= wd[4:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup_mk_q <= 1'b0;
    end else if (usb_bus_reset) begin
      setup_mk_q <= 1'b0;
    // R18 R22 SETUP marker set
    end else if (sie_setup_in_fifo) begin
      setup_mk_q <= 1'b1;
    end else if (misc_wr) begin
      setup_mk_q <= wd[`USBS_FC_SETUP];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_length_packet_flag_q <= 1'b0;
    end else if (usb_bus_reset) begin
      zero_length_packet_flag_q <= 1'b0;
    // R20 R22 zero-length set
    end else if (sie_zero_len_pkt) begin
      zero_length_packet_flag_q <= 1'b1;
    end else if (misc_wr) begin
      zero_length_packet_flag_q <= wd[`USBS_FC_ZERO_LENGTH_PACKET_FLAG];
    end
  end

  // R19 ready status
  always_comb begin
    misc_rd = `USBS_RST_BYTE;
    misc_rd[4:0] = cmd_q;
    misc_rd[`USBS_FC_SETUP] = setup_mk_q;
    misc_rd[`USBS_FC_READY] = ready_sel;
    misc_rd[`USBS_FC_ZERO_LENGTH_PACKET_FLAG] = zero_length_packet_flag_q;
  end

  // ----------------------------------------
  // Outputs to the engine
  // ----------------------------------------
  assign dev_addr = dev_addr_q;
  assign remote_wake_en = awr_q[0];
  // R13 R14 R15 firmware sequences the fields
  assign fifo_req = cmd_q[`USBS_FC_REQ];
  assign fifo_dir_write = cmd_q[`USBS_FC_TX];
  assign fifo_select = cmd_q[`USBS_FC_SEL_HI:`USBS_FC_SEL_LO];
  // R16 flush regardless of ready
  assign fifo_flush = cmd_q[`USBS_FC_REQ] & cmd_q[`USBS_FC_CLEAR];

  // R11 interrupt gating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= nmi_q ? sie_data_xfer : sie_fifo0_access;
    end
  end
  assign usb_irq = irq_q;

  // R10 fault indication
  assign usb_fault = sie_suspend & ~sie_eot;

  // ----------------------------------------
  // Read data, captured in setup phase
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= {24'h00_0000, hit_awr ? awr_q : hit_sie_status_flags ? sie_status_flags_rd : hit_misc ? misc_rd : `USBS_RST_BYTE};
    end
  end
  assign prdata = prdata_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_armed_in;
    adr_set_q && sie_in_done;
  endsequence

  sequence s_addr_loaded;
    (dev_addr_q == $past(awr_q[7:1])) && !adr_set_q;
  endsequence

  property p_r1_deferred;
    @(posedge pclk) disable iff (!presetn)
    s_armed_in |=> s_addr_loaded;
  endproperty
  a_r1_deferred: assert property (p_r1_deferred) else $error("deferred address not loaded"); // R1

  property p_r1_hold;
    @(posedge pclk) disable iff (!presetn)
    (adr_set_q && !sie_in_done) |=> $stable(dev_addr_q);
  endproperty
  a_r1_hold: assert property (p_r1_hold) else $error("address changed before IN done"); // R1

  property p_r2_immediate;
    @(posedge pclk) disable iff (!presetn)
    (wr_en && hit_awr && !adr_set_q) |=> (dev_addr == $past(wd[7:1]));
  endproperty
  a_r2_immediate: assert property (p_r2_immediate) else $error("address not taken on write"); // R2

  property p_r3_clear;
    @(posedge pclk) disable iff (!presetn)
    s_armed_in |=> !adr_set_q ##1 (adr_set_q == $past(sie_status_flags_wr && wd[0]));
  endproperty
  a_r3_clear: assert property (p_r3_clear) else $error("auto address flag not cleared"); // R3

  property p_r4_f0err;
    @(posedge pclk) disable iff (!presetn)
    sie_fifo0_err |=> fifo0_access_error_q;
  endproperty
  a_r4_f0err: assert property (p_r4_f0err) else $error("fifo0 error flag not set"); // R4

  property p_r6_setup_clear;
    @(posedge pclk) disable iff (!presetn)
    (sie_setup_token && !sie_out_data) |=> !out_q;
  endproperty
  a_r6_setup_clear: assert property (p_r6_setup_clear) else $error("OUT flag not cleared by SETUP"); // R6

  property p_r9_crc;
    @(posedge pclk) disable iff (!presetn)
    (crc_q && !sie_status_flags_wr) |=> crc_q;
  endproperty
  a_r9_crc: assert property (p_r9_crc) else $error("CRC flag dropped without firmware"); // R9

  property p_r11_irq;
    @(posedge pclk) disable iff (!presetn)
    (!nmi_q && sie_fifo0_access) or (nmi_q && sie_data_xfer) |=> usb_irq;
  endproperty
  a_r11_irq: assert property (p_r11_irq) else $error("interrupt missing"); // R11

  property p_r11_mask;
    @(posedge pclk) disable iff (!presetn)
    (nmi_q && !sie_data_xfer) |=> !usb_irq;
  endproperty
  a_r11_mask: assert property (p_r11_mask) else $error("masked access raised interrupt"); // R11

  property p_r12_reset;
    @(posedge pclk) disable iff (!presetn)
    usb_bus_reset |=> (misc_rd[5:0] == 6'h00) && !zero_length_packet_flag_q;
  endproperty
  a_r12_reset: assert property (p_r12_reset) else $error("command register not zeroed"); // R12

  property p_r16_flush;
    @(posedge pclk) disable iff (!presetn)
    (misc_wr && wd[0] && wd[2] && !usb_bus_reset) |=> fifo_flush;
  endproperty
  a_r16_flush: assert property (p_r16_flush) else $error("flush not issued"); // R16

  property p_r18_setup;
    @(posedge pclk) disable iff (!presetn)
    (sie_setup_in_fifo && !usb_bus_reset) |=> setup_mk_q [*1] ##0 misc_rd[5];
  endproperty
  a_r18_setup: assert property (p_r18_setup) else $error("SETUP marker not set"); // R18

  property p_r20_zero_length_packet_flag;
    @(posedge pclk) disable iff (!presetn)
    (sie_zero_len_pkt && !usb_bus_reset) |=> zero_length_packet_flag_q;
  endproperty
  a_r20_zero_length_packet_flag: assert property (p_r20_zero_length_packet_flag) else $error("zero-length flag not set"); // R20

  property p_r22_set_wins;
    @(posedge pclk) disable iff (!presetn)
    (sie_out_data && sie_status_flags_wr && !wd[2]) |=> out_q;
  endproperty
  a_r22_set_wins: assert property (p_r22_set_wins) else $error("clear beat hardware set"); // R22

endmodule : usbs_sie_regs
`default_nettype wire

// File: rtl/usbs_cfg.svh
// Register map, field positions, reset values and timing for the USB SIE status block
`ifndef USBS_CFG_SVH
`define USBS_CFG_SVH

// ----------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------
`define USBS_IDX_AWR 8'h42
`define USBS_IDX_SIE_STATUS_FLAGS 8'h45
`define USBS_IDX_MISC 8'h46

// ----------------------------------------
// Status flag field positions
// ----------------------------------------
`define USBS_SF_ADR_SET 0
`define USBS_SF_FIFO0_ACCESS_ERROR 1
`define USBS_SF_OUT 2
`define USBS_SF_IN 3
`define USBS_SF_NAK 4
`define USBS_SF_CRC 5
`define USBS_SF_EOT 6
`define USBS_SF_NMI 7

// ----------------------------------------
// FIFO command field positions
// ----------------------------------------
`define USBS_FC_REQ 0
`define USBS_FC_TX 1
`define USBS_FC_CLEAR 2
`define USBS_FC_SEL_LO 3
`define USBS_FC_SEL_HI 4
`define USBS_FC_SETUP 5
`define USBS_FC_READY 6
`define USBS_FC_ZERO_LENGTH_PACKET_FLAG 7

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define USBS_RST_AWR 8'h00
`define USBS_RST_BYTE 8'h00
`define USBS_FIFO_GAP_NS 2000
`define USBS_CLK_NS 25

`endif

// File: rtl/usbs_pkg.sv
// Types shared by the USB SIE status block
`default_nettype none
package usbs_pkg;

  typedef logic [7:0] usbs_byte_t;

  typedef enum logic [1:0] {
    USBS_EP_FIFO0,
    USBS_EP_FIFO1,
    USBS_EP_FIFO2,
    USBS_EP_RSVD
  } usbs_ep_e;

  typedef enum logic [1:0] {
    USBS_ADR_IDLE,
    USBS_ADR_ARMED
  } usbs_adr_e;

endpackage : usbs_pkg
`default_nettype wire

// File: test/usbs_host_model.sv
// Behavioural host side of the link: one-cycle SIE event strobes
`timescale 1ns/1ps
`default_nettype none

module usbs_host_model (
  input wire logic pclk,
  output logic [9:0] ev,
  output logic in_tok,
  output logic nak,
  output logic transaction_end_flag,
  output logic susp,
  output logic [2:0] fifo_ready
);
  initial begin
    ev = 10'h000;
    in_tok = 1'b0;
    nak = 1'b0;
    transaction_end_flag = 1'b1;
    susp = 1'b0;
    fifo_ready = 3'h0;
  end

  // ----------------------------------------
  // Event strobe, one cycle wide
  // ----------------------------------------
  // Any event, selected by bit n of ev
  task automatic send(input int unsigned n);
    @(posedge pclk);
    ev <= 10'(1 << n);
    @(posedge pclk);
    ev <= 10'h000;
  endtask : send

  // ----------------------------------------
  // Engine levels, changed just after an edge
  // ----------------------------------------
  task automatic levels(input logic [3:0] lv, input logic [2:0] rdy);
    @(posedge pclk);
    {in_tok, nak, transaction_end_flag, susp} <= lv;
    fifo_ready <= rdy;
  endtask : levels
endmodule : usbs_host_model

`default_nettype wire

// File: test/usb_sie_status_fifo_access_tb_top.sv
// Register-level bench for the SIE status and FIFO command block
`timescale 1ns/1ps
`default_nettype none
`include "usbs_cfg.svh"

module usb_sie_status_fifo_access_tb_top;
  localparam logic [11:0] A_AWR = 12'(`USBS_IDX_AWR * 4);
  localparam logic [11:0] A_SIE_STATUS_FLAGS = 12'(`USBS_IDX_SIE_STATUS_FLAGS * 4);
  localparam logic [11:0] A_MISC = 12'(`USBS_IDX_MISC * 4);
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic in_tok, nak, transaction_end_flag, susp, err, hit;
  logic [2:0] fifo_ready;
  logic [9:0] ev;
  logic [31:0] prdata;
  logic pready, pslverr, wake, freq, fdir, fflush, irq, fault;
  logic [6:0] dev_addr;
  logic [1:0] fsel;
  logic [7:0] rd;
  logic [7:0] seq [8] = '{8'h0A, 8'h0B, 8'h09, 8'h08, 8'h00, 8'h01, 8'h03, 8'h02};
  int bad_count = 0;
  int total_checks = 0;

  usbs_host_model u_host (.pclk(pclk), .ev(ev), .in_tok(in_tok), .nak(nak), .transaction_end_flag(transaction_end_flag), .susp(susp),
    .fifo_ready(fifo_ready));

  usbs_sie_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sie_in_token(in_tok), .sie_nak_tx(nak), .sie_eot(transaction_end_flag),
    .sie_suspend(susp), .sie_crc_err(ev[0]), .sie_fifo0_err(ev[1]), .sie_out_data(ev[2]),
    .sie_setup_token(ev[3]), .sie_in_done(ev[4]), .sie_setup_in_fifo(ev[5]),
    .sie_zero_len_pkt(ev[6]), .sie_fifo0_access(ev[7]), .sie_data_xfer(ev[8]),
    .usb_bus_reset(ev[9]), .fifo_ready(fifo_ready), .dev_addr(dev_addr),
    .remote_wake_en(wake), .fifo_req(freq), .fifo_dir_write(fdir), .fifo_flush(fflush),
    .fifo_select(fsel), .usb_irq(irq), .usb_fault(fault));

  initial begin
    forever #12.5 pclk = ~pclk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic settle;
    hit = 1'b0;
    repeat (2) begin
      @(negedge pclk);
      hit = hit | irq;
    end
  endtask : settle

  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  initial begin
    #(25 * 6000);
    bad_count++;
    stop_test();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    xfer(0, A_SIE_STATUS_FLAGS, 8'h00);
    chk(rd, 8'h40);
    chk({7'h00, fault}, 8'h00);
    xfer(0, A_MISC, 8'h00);
    chk(rd, 8'h00);
    xfer(1, A_AWR, 8'h0B);
    settle();
    chk({1'b0, dev_addr}, 8'h05);
    chk({7'h00, wake}, 8'h01);
    xfer(1, A_SIE_STATUS_FLAGS, 8'h01);
    xfer(1, A_AWR, 8'h14);
    settle();
    chk({1'b0, dev_addr}, 8'h05);
    u_host.send(4);
    settle();
    chk({1'b0, dev_addr}, 8'h0A);
    xfer(0, A_SIE_STATUS_FLAGS, 8'h00);
    chk(rd, 8'h40);
    u_host.send(1);
    u_host.send(0);
    u_host.send(2);
    xfer(0, A_SIE_STATUS_FLAGS, 8'h00);
    chk(rd, 8'h66);
    xfer(1, A_SIE_STATUS_FLAGS, 8'h00);
    xfer(0, A_SIE_STATUS_FLAGS, 8'h00);
    chk(rd, 8'h40);
    u_host.send(2);
    u_host.send(3);
    xfer(0, A_SIE_STATUS_FLAGS, 8'h00);
    chk(rd, 8'h40);
    u_host.levels(4'b1110, 3'h0);
    xfer(0, A_SIE_STATUS_FLAGS, 8'h00);
    chk(rd, 8'h58);
    u_host.levels(4'b0001, 3'h0);
    xfer(0, A_SIE_STATUS_FLAGS, 8'h00);
    chk(rd, 8'h00);
    chk({7'h00, fault}, 8'h01);
    u_host.levels(4'b0010, 3'h0);
    for (int m = 0; m < 2; m++) begin
      xfer(1, A_SIE_STATUS_FLAGS, {m[0], 7'h00});
      for (int e = 7; e < 9; e++) begin
        u_host.send(e);
        settle();
        chk({7'h00, hit}, 8'(m == 1 ? e == 8 : e == 7));
      end
    end
    for (int i = 0; i < 8; i++) begin
      xfer(1, A_MISC, seq[i]);
      settle();
      chk({4'h0, fsel, fdir, freq}, {4'h0, seq[i][4:3], seq[i][1:0]});
      if (seq[i][0]) begin
        repeat (`USBS_FIFO_GAP_NS / `USBS_CLK_NS) @(posedge pclk);
      end
    end
    u_host.levels(4'b0010, 3'b101);
    for (int s = 0; s < 4; s++) begin
      xfer(1, A_MISC, {3'b000, s[1:0], 3'b001});
      xfer(0, A_MISC, 8'h00);
      chk(rd, {1'b0, (s < 3) ? fifo_ready[s] : 1'b0, 1'b0, s[1:0], 3'b001});
    end
    xfer(1, A_MISC, 8'h0D);
    settle();
    chk({7'h00, fflush}, 8'h01);
    xfer(1, A_MISC, 8'h01);
    u_host.send(5);
    chk({7'h00, fflush}, 8'h00);
    u_host.send(6);
    xfer(0, A_MISC, 8'h00);
    chk(rd, 8'hE1);
    u_host.send(9);
    xfer(0, A_MISC, 8'h00);
    chk(rd, 8'h40);
    xfer(0, 12'h200, 8'h00);
    chk(rd, 8'h00);
    chk({7'h00, err}, 8'h01);
    stop_test();
  end
endmodule : usb_sie_status_fifo_access_tb_top

`default_nettype wire
